// *** scg_map.svh ***
// Register offsets, field positions and reset values of the unit clock gating block
`ifndef SCG_MAP_SVH
`define SCG_MAP_SVH
`define SCG_ADDR_W 12
`define SCG_OFF_RUN 12'h100
`define SCG_OFF_SLEEP 12'h110
`define SCG_OFF_DEEP 12'h120
`define SCG_OFF_CFG 12'h060
`define SCG_OFF_STAT 12'h130
`define SCG_OFF_MASK 12'h134
`define SCG_BIT_PWM 20
`define SCG_BIT_CONV 16
`define SCG_RATE_HI 9
`define SCG_RATE_LO 8
`define SCG_BIT_WDOG 3
`define SCG_GATE_WMASK 32'h0011_0308
`define SCG_GATE_RST 32'h0000_0000
`define SCG_BIT_AUTO 0
`define SCG_CFG_WMASK 32'h0000_0001
`define SCG_CFG_RST 32'h0000_0000
`define SCG_RATE_RST 2'h0
`define SCG_EVT_W 2
`define SCG_EVT_FAULT 0
`define SCG_EVT_MODE 1
`define SCG_NUNITS 3
`endif

// *** scg_pkg.sv ***
// Types shared by the unit clock gating block
package scg_pkg;
    typedef enum logic [1:0] {
        SCG_RUN,
        SCG_SLEEP,
        SCG_DEEP
    } scg_pwr_e;
    typedef struct packed {
        logic pwm;
        logic conv;
        logic wdog;
    } scg_units_s;
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } scg_req_s;
endpackage

// *** scg_gate_reg.sv ***
// One gating register: writable fields only, reserved bits held at zero
`timescale 1ns/100ps
`include "scg_map.svh"
module scg_gate_reg (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Write access
    input wire logic we,
    input wire logic [31:0] wdata,
    // Register value
    output logic [31:0] value
);
    logic [31:0] next_value;

    // Reserved bits ignore writes and read as zero
    assign next_value = wdata & `SCG_GATE_WMASK;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            value <= `SCG_GATE_RST;
        end else if (we) begin
            value <= next_value;
        end
    end
endmodule

// *** scg_unit_sel.sv ***
// Picks the gating register for the current power state when auto gating is on, else the run register
`timescale 1ns/100ps
`include "scg_map.svh"
module scg_unit_sel (
    // Power state and mode
    input wire scg_pkg::scg_pwr_e pwr,
    input wire logic auto_gating_select,
    // Gating registers
    input wire logic [31:0] run_gate,
    input wire logic [31:0] sleep_gate,
    input wire logic [31:0] deep_gate,
    // Selected register
    output logic [31:0] sel_gate
);
    wire use_sleep = auto_gating_select && (pwr == scg_pkg::SCG_SLEEP);
    wire use_deep = auto_gating_select && (pwr == scg_pkg::SCG_DEEP);

    assign sel_gate = use_deep ? deep_gate : (use_sleep ? sleep_gate : run_gate);
endmodule

// *** scg_top.sv ***
// Unit clock gating controller with register port, fault check and interrupt
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`include "scg_map.svh"
module scg_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Power state from the power manager
    input wire scg_pkg::scg_pwr_e pwr_state,
    // Peripheral accesses from the system bus
    input wire logic [`SCG_NUNITS-1:0] periph_req,
    output logic [`SCG_NUNITS-1:0] periph_fault,
    // Unit clock enables and converter rate
    output scg_pkg::scg_units_s unit_clk_en,
    output logic [1:0] converter_sample_rate,
    // Interrupt
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    scg_pkg::scg_req_s req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    wire hit_run = req.addr == `SCG_OFF_RUN;
    wire hit_sleep = req.addr == `SCG_OFF_SLEEP;
    wire hit_deep = req.addr == `SCG_OFF_DEEP;
    wire hit_cfg = req.addr == `SCG_OFF_CFG;
    wire hit_stat = req.addr == `SCG_OFF_STAT;
    wire hit_mask = req.addr == `SCG_OFF_MASK;

    ////////////////////////////////////////////////////////////////////////////
    // Gating registers
    logic [31:0] run_unit_clock_gate;
    logic [31:0] sleep_unit_clock_gate;
    logic [31:0] deep_sleep_unit_clock_gate;
    logic [31:0] sel_gate;

    scg_gate_reg u_run (
        .core_clk(core_clk),
        .rst(rst),
        .we(req.wr && hit_run),
        .wdata(req.wdata),
        .value(run_unit_clock_gate)
    );
    scg_gate_reg u_sleep (
        .core_clk(core_clk),
        .rst(rst),
        .we(req.wr && hit_sleep),
        .wdata(req.wdata),
        .value(sleep_unit_clock_gate)
    );
    scg_gate_reg u_deep (
        .core_clk(core_clk),
        .rst(rst),
        .we(req.wr && hit_deep),
        .wdata(req.wdata),
        .value(deep_sleep_unit_clock_gate)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Run-mode clock configuration: auto gating bit
    logic [31:0] run_clock_config;
    logic auto_gating_select;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            run_clock_config <= `SCG_CFG_RST;
        end else if (req.wr && hit_cfg) begin
            run_clock_config <= req.wdata & `SCG_CFG_WMASK;
        end
    end
    assign auto_gating_select = run_clock_config[`SCG_BIT_AUTO];

    scg_unit_sel u_sel (
        .pwr(pwr_state),
        .auto_gating_select(auto_gating_select),
        .run_gate(run_unit_clock_gate),
        .sleep_gate(sleep_unit_clock_gate),
        .deep_gate(deep_sleep_unit_clock_gate),
        .sel_gate(sel_gate)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Effective enables, registered
    scg_pkg::scg_units_s next_en;
    logic [1:0] next_rate;
    assign next_en.pwm = sel_gate[`SCG_BIT_PWM];
    assign next_en.conv = sel_gate[`SCG_BIT_CONV];
    assign next_en.wdog = sel_gate[`SCG_BIT_WDOG];
    assign next_rate = sel_gate[`SCG_RATE_HI:`SCG_RATE_LO];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            unit_clk_en <= '0;
            converter_sample_rate <= `SCG_RATE_RST;
        end else begin
            unit_clk_en <= next_en;
            converter_sample_rate <= next_rate;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault on access to an unclocked unit, one generate per unit
    logic [`SCG_NUNITS-1:0] en_vec;
    assign en_vec = unit_clk_en;

    genvar gi;
    generate
        for (gi = 0; gi < `SCG_NUNITS; gi++) begin : g_fault
            assign periph_fault[gi] = periph_req[gi] && !en_vec[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask
    logic [`SCG_EVT_W-1:0] irq_status;
    logic [`SCG_EVT_W-1:0] irq_mask;
    logic [`SCG_EVT_W-1:0] evt;
    logic [`SCG_EVT_W-1:0] w1c;
    scg_pkg::scg_pwr_e pwr_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pwr_q <= scg_pkg::SCG_RUN;
        end else begin
            pwr_q <= pwr_state;
        end
    end

    assign evt[`SCG_EVT_FAULT] = |periph_fault;
    assign evt[`SCG_EVT_MODE] = pwr_q != pwr_state;
    assign w1c = (req.wr && hit_stat) ? req.wdata[`SCG_EVT_W-1:0] : '0;

    // Setting wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_status <= '0;
            irq_mask <= '0;
        end else begin
            irq_status <= (irq_status & ~w1c) | evt;
            if (req.wr && hit_mask) begin
                irq_mask <= req.wdata[`SCG_EVT_W-1:0];
            end
        end
    end
    assign irq = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe
    logic [31:0] rd_mux;
    assign rd_mux = hit_run ? run_unit_clock_gate :
                    hit_sleep ? sleep_unit_clock_gate :
                    hit_deep ? deep_sleep_unit_clock_gate :
                    hit_cfg ? run_clock_config :
                    hit_stat ? {30'h0, irq_status} :
                    hit_mask ? {30'h0, irq_mask} : 32'h0000_0000;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (req.rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    a_fault_when_gated: assert property (@(posedge core_clk) disable iff (rst)
        periph_req[2] && !unit_clk_en.pwm |-> periph_fault[2])
        else $error("access to gated waveform unit did not fault");
    a_conv_gated_fault: assert property (@(posedge core_clk) disable iff (rst)
        periph_req[1] && !unit_clk_en.conv |-> periph_fault[1])
        else $error("access to gated converter did not fault");
    a_wdog_gated_fault: assert property (@(posedge core_clk) disable iff (rst)
        periph_req[0] && !unit_clk_en.wdog |-> periph_fault[0])
        else $error("access to gated watchdog did not fault");
    a_wdog_follows_sel: assert property (@(posedge core_clk) disable iff (rst)
        1'b1 |=> unit_clk_en.wdog == $past(sel_gate[`SCG_BIT_WDOG]))
        else $error("watchdog enable does not follow selected register");
    a_run_when_manual: assert property (@(posedge core_clk) disable iff (rst)
        !auto_gating_select |=> unit_clk_en.conv == $past(run_unit_clock_gate[`SCG_BIT_CONV]))
        else $error("converter enable not from run register with auto gating off");
    a_deep_selects: assert property (@(posedge core_clk) disable iff (rst)
        auto_gating_select && pwr_state == scg_pkg::SCG_DEEP
        |=> unit_clk_en.pwm == $past(deep_sleep_unit_clock_gate[`SCG_BIT_PWM]))
        else $error("deep-sleep register not applied");
    a_sleep_selects: assert property (@(posedge core_clk) disable iff (rst)
        auto_gating_select && pwr_state == scg_pkg::SCG_SLEEP
        |=> unit_clk_en.conv == $past(sleep_unit_clock_gate[`SCG_BIT_CONV]))
        else $error("sleep register not applied");
    a_run_selects: assert property (@(posedge core_clk) disable iff (rst)
        pwr_state == scg_pkg::SCG_RUN
        |=> unit_clk_en.pwm == $past(run_unit_clock_gate[`SCG_BIT_PWM]))
        else $error("run register not applied in run state");
    a_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
        (sleep_unit_clock_gate & ~`SCG_GATE_WMASK) == 32'h0)
        else $error("reserved gating bit set");
    a_run_reserved: assert property (@(posedge core_clk) disable iff (rst)
        (run_unit_clock_gate & ~`SCG_GATE_WMASK) == 32'h0)
        else $error("reserved run gating bit set");
    a_deep_reserved: assert property (@(posedge core_clk) disable iff (rst)
        (deep_sleep_unit_clock_gate & ~`SCG_GATE_WMASK) == 32'h0)
        else $error("reserved deep-sleep gating bit set");
    a_cfg_reserved: assert property (@(posedge core_clk) disable iff (rst)
        (run_clock_config & ~`SCG_CFG_WMASK) == 32'h0)
        else $error("reserved configuration bit set");
    a_deep_write_kept: assert property (@(posedge core_clk) disable iff (rst)
        req.wr && hit_deep
        |=> deep_sleep_unit_clock_gate == ($past(req.wdata) & `SCG_GATE_WMASK))
        else $error("deep-sleep register write not stored");
    a_sleep_write_kept: assert property (@(posedge core_clk) disable iff (rst)
        req.wr && hit_sleep
        |=> sleep_unit_clock_gate == ($past(req.wdata) & `SCG_GATE_WMASK))
        else $error("sleep register write not stored");
    a_run_write_kept: assert property (@(posedge core_clk) disable iff (rst)
        req.wr && hit_run
        |=> run_unit_clock_gate == ($past(req.wdata) & `SCG_GATE_WMASK))
        else $error("run register write not stored");
    a_sleep_read: assert property (@(posedge core_clk) disable iff (rst)
        req.rd && hit_sleep |=> reg_rdata == $past(sleep_unit_clock_gate))
        else $error("sleep register read mismatch");
    a_unmapped_read: assert property (@(posedge core_clk) disable iff (rst)
        req.rd && !(hit_run || hit_sleep || hit_deep || hit_cfg || hit_stat || hit_mask)
        |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_rate_field: assert property (@(posedge core_clk) disable iff (rst)
        1'b1 |=> converter_sample_rate == $past(sel_gate[`SCG_RATE_HI:`SCG_RATE_LO]))
        else $error("converter rate does not follow register");
    a_deep_rate: assert property (@(posedge core_clk) disable iff (rst)
        auto_gating_select && pwr_state == scg_pkg::SCG_DEEP
        |=> converter_sample_rate == $past(deep_sleep_unit_clock_gate[`SCG_RATE_HI:`SCG_RATE_LO]))
        else $error("deep-sleep rate not applied");
    a_reset_gated: assert property (@(posedge core_clk)
        rst |=> unit_clk_en == '0 && run_unit_clock_gate == 32'h0)
        else $error("enables not cleared by reset");
    a_reset_rate: assert property (@(posedge core_clk)
        rst |=> converter_sample_rate == 2'h0 && sleep_unit_clock_gate == 32'h0)
        else $error("rate or sleep register not cleared by reset");
    a_enable_no_fault: assert property (@(posedge core_clk) disable iff (rst)
        unit_clk_en.conv |-> !periph_fault[1])
        else $error("fault on clocked converter");
    a_fault_sets_status: assert property (@(posedge core_clk) disable iff (rst)
        |periph_fault |=> irq_status[`SCG_EVT_FAULT])
        else $error("fault event not recorded");
    a_mode_sets_status: assert property (@(posedge core_clk) disable iff (rst)
        pwr_q != pwr_state |=> irq_status[`SCG_EVT_MODE])
        else $error("power state change not recorded");

    c_fault_seen: cover property (@(posedge core_clk) disable iff (rst) |periph_fault);
    c_deep_auto: cover property (@(posedge core_clk) disable iff (rst)
        auto_gating_select && pwr_state == scg_pkg::SCG_DEEP && unit_clk_en.wdog);
    c_sleep_auto: cover property (@(posedge core_clk) disable iff (rst)
        auto_gating_select && pwr_state == scg_pkg::SCG_SLEEP && unit_clk_en.conv);
    c_set_beats_clear: cover property (@(posedge core_clk) disable iff (rst)
        (|periph_fault) && w1c[`SCG_EVT_FAULT]);
    c_irq_raised: cover property (@(posedge core_clk) disable iff (rst) $rose(irq));
endmodule

// *** scg_top_test.sv ***
// Self-checking testbench of the unit clock gating controller
`timescale 1ns/100ps
`include "scg_map.svh"
module scg_top_test;
    logic core_clk;
    logic rst;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    scg_pkg::scg_pwr_e pwr_state;
    logic [2:0] periph_req;
    logic [2:0] periph_fault;
    scg_pkg::scg_units_s unit_clk_en;
    logic [1:0] converter_sample_rate;
    logic irq;
    int err_count = 0;
    int checks = 0;
    logic [31:0] seed = 32'h0000_0033;
    logic [31:0] rv;
    logic [31:0] g [3];
    logic [31:0] sel;
    logic auto;

    scg_top dut_u (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwr_state(pwr_state),
        .periph_req(periph_req), .periph_fault(periph_fault), .unit_clk_en(unit_clk_en),
        .converter_sample_rate(converter_sample_rate), .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    // Register chosen by power state when auto gating is on, else the run register
    function automatic logic [31:0] pick(input logic a, input logic [1:0] p,
                                         input logic [31:0] r, s, d);
        if (!a || p == 2'h0) begin
            return r;
        end
        return (p == 2'h1) ? s : d;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic wrap_up();
        $display("Checks %0d, errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    initial begin
        #100000;
        err_count++;
        wrap_up();
    end

    initial begin
        rst = 1'b1;
        reg_addr = 12'h000;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        pwr_state = scg_pkg::SCG_RUN;
        periph_req = 3'h0;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        // Reset state: run, sleep and deep-sleep gating registers, enables and interrupt clear
        rd(`SCG_OFF_RUN, rv); check(rv, 32'h0, "run reset");
        rd(`SCG_OFF_SLEEP, rv); check(rv, 32'h0, "sleep reset");
        rd(`SCG_OFF_DEEP, rv); check(rv, 32'h0, "deep reset");
        check({29'h0, unit_clk_en}, 32'h0, "enables reset");
        check({31'h0, irq}, 32'h0, "irq reset");
        // Unmapped place reads zero and ignores writes
        wr(12'h124, 32'hffff_ffff);
        rd(12'h124, rv); check(rv, 32'h0, "unmapped");
        for (int i = 0; i < 12; i++) begin
            auto = i[0];
            pwr_state <= scg_pkg::scg_pwr_e'(i % 3);
            // Rate codes kept within 0..2
            for (int k = 0; k < 3; k++) begin
                g[k] = (rnd() & 32'hffff_fcff) | (32'((i + k) % 3) << 8);
            end
            wr(`SCG_OFF_CFG, {31'h0, auto});
            wr(`SCG_OFF_RUN, g[0]);
            wr(`SCG_OFF_SLEEP, g[1]);
            wr(`SCG_OFF_DEEP, g[2]);
            rd(`SCG_OFF_SLEEP, rv); check(rv, g[1] & `SCG_GATE_WMASK, "sleep rb");
            rd(`SCG_OFF_DEEP, rv); check(rv, g[2] & `SCG_GATE_WMASK, "deep rb");
            rd(`SCG_OFF_RUN, rv); check(rv, g[0] & `SCG_GATE_WMASK, "run rb");
            rd(`SCG_OFF_CFG, rv); check(rv, {31'h0, auto}, "cfg rb");
            sel = pick(auto, 2'(i % 3), g[0], g[1], g[2]);
            check({29'h0, unit_clk_en}, {29'h0, sel[20], sel[16], sel[3]}, "en");
            check({30'h0, converter_sample_rate}, {30'h0, sel[9:8]}, "rate");
            // Expected enables in port order: waveform, converter, watchdog
            sel = {29'h0, sel[20], sel[16], sel[3]};
            rv = rnd();
            @(posedge core_clk);
            periph_req <= rv[2:0];
            #1;
            check({29'h0, periph_fault}, {29'h0, rv[2:0]} & ~sel, "fault");
            periph_req <= 3'h0;
        end
        rd(`SCG_OFF_STAT, rv); check(rv & 32'h2, 32'h2, "mode event");
        // Sticky fault status, masked and unmasked interrupt
        wr(`SCG_OFF_CFG, 32'h0);
        wr(`SCG_OFF_RUN, 32'h0);
        wr(`SCG_OFF_STAT, 32'h3);
        wr(`SCG_OFF_MASK, 32'h0);
        @(posedge core_clk);
        periph_req <= 3'h1;
        @(posedge core_clk);
        periph_req <= 3'h0;
        #1;
        check({31'h0, irq}, 32'h0, "masked irq");
        rd(`SCG_OFF_STAT, rv); check(rv & 32'h1, 32'h1, "fault sticky");
        wr(`SCG_OFF_MASK, 32'h1);
        check({31'h0, irq}, 32'h1, "irq raised");
        wr(`SCG_OFF_STAT, 32'h1);
        check({31'h0, irq}, 32'h0, "irq cleared");
        // Enabled unit does not fault
        wr(`SCG_OFF_RUN, 32'h0000_0008);
        @(posedge core_clk);
        periph_req <= 3'h1;
        #1;
        check({29'h0, periph_fault}, 32'h0, "wdog clocked");
        periph_req <= 3'h0;
        repeat (2) @(posedge core_clk);
        #1;
        check({31'h0, irq}, 32'h0, "no fault irq");
        wrap_up();
    end
endmodule
